// ===== pkg/tdiv_pkg.sv
// Shared constants for the ten-channel reload divider block and its controller
package tdiv_pkg;
    localparam int NCH = 10;
    localparam int NFLAG = 7;
    // Device register offsets
    localparam logic [7:0] OFF_CSR = 8'ha0;
    localparam logic [7:0] OFF_PRESCALE = 8'ha1;
    localparam logic [7:0] OFF_CASCADE = 8'ha4;
    // Reload offsets, indexed by channel minus one
    localparam logic [7:0] RELOAD_OFF [NCH] = '{8'ha3, 8'ha5, 8'ha7, 8'ha9, 8'hab,
                                                8'had, 8'haf, 8'ha6, 8'ha8, 8'haa};
    // Field positions
    localparam int CSR_EN_BIT = 0;
    localparam int CSR_FLAG_LSB = 1;
    localparam int PRESCALE_HALF_BIT = 0;
    localparam int CASC_LSB = 2;
    localparam int PRIO_LSB = 0;
    // Reset values
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] PRESCALE_RST = 8'h01;
    localparam logic [7:0] CASCADE_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    // Shared interrupt table offset
    localparam logic [7:0] IRQ_VEC_OFF = 8'ha0;
    // Controller register offsets
    localparam logic [3:0] H_OFF_ADDR = 4'h0;
    localparam logic [3:0] H_OFF_WDATA = 4'h1;
    localparam logic [3:0] H_OFF_CMD = 4'h2;
    localparam logic [3:0] H_OFF_RESULT = 4'h3;
    localparam logic [3:0] H_OFF_STATUS = 4'h4;
    localparam logic [3:0] H_OFF_SEEN_LO = 4'h5;
    localparam logic [3:0] H_OFF_SEEN_HI = 4'h6;
    localparam int H_CMD_WR_BIT = 0;
    localparam int H_CMD_RD_BIT = 1;
endpackage : tdiv_pkg

// ===== pkg/tdiv_if.sv
// Link between the divider block and its controller and peripherals
interface tdiv_if;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_rdata;
    logic [tdiv_pkg::NCH-1:0] tick;
    logic irq_req;
    logic [1:0] irq_prio;

    modport dev (
        input io_addr,
        input io_wdata,
        input io_wr,
        input io_rd,
        output io_rdata,
        output tick,
        output irq_req,
        output irq_prio
    );
    modport host (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        input io_rdata,
        input tick,
        input irq_req,
        input irq_prio
    );
endinterface : tdiv_if

// ===== hw/tdiv_timers.sv
// Ten auto-reload 8-bit divider channels with shared status and interrupt
//
// Behaviour
// - ten independent 8-bit countdown counters
// - divide input pulse rate by reload plus one
// - reload 0 to 255, zero divides by one
// - at zero, next pulse reloads instead of decrementing
// - one-clock outputs except reload 0 with an input pulse every clock (held high), cascade advances on pulse end
// - base clock is clock or clock halved
// - channels 2-7 may cascade from channel 1
// - channels 8-10 feed capture, PWM, decoder; no interrupts
// - channels 2-7 give serial port baud clocks
// - no pin output; channel 1 strobes ports
// - control bit 0 gates all ten counters
// - channels 1-7 set flags; status read clears
// - event during status read is never lost
// - one shared request from enabled set flags
// - status read withdraws the pending request
// - software handles every flag it sees set
// - priority 1-3 programmable; nonzero level enables
// - request dispatches through fixed table offset
// - software sets clocks, cascades, reloads, then enable
// - software sets vector, enables, then priority last
// - cascade bits 7:2, priority in bits 1:0
// - prescale bit 0 selects halved clock
// - status bits 7:1 write enables, read flags
module tdiv_timers #(
    parameter int NCH = tdiv_pkg::NCH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    tdiv_if.dev bus,
    output logic [7:0] irq_vector_offset
);
    localparam int NF = tdiv_pkg::NFLAG;

    // Register map as seen on the device bus
    // 0xa0 write: enables of channels 7..1 in 7:1, run in bit 0
    // 0xa0 read: terminal-count flags in 7:1, bit 0 reads zero
    // 0xa1 write: bit 0 set halves the base clock, halved after reset
    // 0xa4 write: cascade from channel 1 in 7:2, priority in 1:0
    // Reload values: ten write-only bytes at scattered offsets
    // Write-only and unmapped offsets read zero, so software keeps
    // its own copy of whatever it needs back

    // Timing, counted in clock edges after a strobe
    // Control writes take effect one edge after the strobe
    // A channel ticks one edge after the input pulse that wraps it
    // A flag sets one edge after its tick and holds until read
    // Read data stand one cycle after the strobe, zero otherwise
    // Limitations
    // Cascading only from channel 1; no chaining between others
    // Halved base restarts its phase whenever run drops

    // Control and status state
    logic [7:0] csr_q;
    logic [7:0] csr_d;
    logic [NF-1:0] flag_q;
    logic [NF-1:0] flag_d;
    logic [7:0] prescale_q;
    logic [7:0] prescale_d;
    logic [7:0] cascade_q;
    logic [7:0] cascade_d;
    // Base clock halving
    logic half_q;
    logic half_d;
    // Read path, one cycle behind the strobe
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // Channel ticks and the pulses that step each counter
    logic [NCH-1:0] pulse_q;
    logic [NCH-1:0] pulse_d;
    logic [NCH-1:0] in_pulse;

    // Address decode; strobes are single cycles and the bus never
    // waits, so a decode only matters in the strobe cycle itself
    wire logic sel_csr = bus.io_addr == tdiv_pkg::OFF_CSR;
    wire logic sel_pre = bus.io_addr == tdiv_pkg::OFF_PRESCALE;
    wire logic sel_casc = bus.io_addr == tdiv_pkg::OFF_CASCADE;
    wire logic wr_csr = bus.io_wr && sel_csr;
    wire logic rd_csr = bus.io_rd && sel_csr;
    wire logic wr_pre = bus.io_wr && sel_pre;
    wire logic wr_casc = bus.io_wr && sel_casc;

    // Base tick; the global enable gates every channel, cascaded ones included
    wire logic run = csr_q[tdiv_pkg::CSR_EN_BIT];
    wire logic halved = prescale_q[tdiv_pkg::PRESCALE_HALF_BIT];
    wire logic base_tick = run && (halved ? half_q : 1'b1);

    // Flags: a pulse in the read cycle sets after the read, set beats clear.
    // The read returns the flags as they stood before that edge, so an
    // event is either in the returned byte or waiting for the next read
    wire logic [NF-1:0] events = pulse_q[NF-1:0];
    assign flag_d = (flag_q & ~{NF{rd_csr}}) | events;

    // Control word keeps enables; status read never touches them
    // Bit 0 is the global run gate, bits 7:1 the interrupt enables
    assign csr_d = wr_csr ? bus.io_wdata : csr_q;

    // Read data: flags in 7:1, write-only and unmapped bytes read zero
    // Registered, so the answer stands exactly one cycle after the strobe
    assign rdata_d = (bus.io_rd && sel_csr) ? {flag_q, 1'b0} : 8'h00;

    // Shared request; cleared flags drop it, zero priority masks it.
    // One request serves all seven flags: a flag that sets while the
    // request stands raises no second one, and a flag cleared by a read
    // never requests again, so a handler must act on every bit it reads
    wire logic [1:0] prio = cascade_q[tdiv_pkg::PRIO_LSB +: 2];
    wire logic any_enabled = |(flag_q & csr_q[tdiv_pkg::CSR_FLAG_LSB +: NF]);
    assign bus.irq_req = any_enabled && (prio != 2'b00);
    assign bus.irq_prio = prio;
    assign bus.io_rdata = rdata_q;
    assign irq_vector_offset = tdiv_pkg::IRQ_VEC_OFF;

    // Outputs reach peripherals only, never a pin
    assign bus.tick = pulse_q;

    // Write-only controls; other offsets leave them alone
    assign prescale_d = wr_pre ? bus.io_wdata : prescale_q;
    assign cascade_d = wr_casc ? bus.io_wdata : cascade_q;

    // Halving phase; held low while stopped so a restart is predictable
    // Half rate gives a base tick on every other clock, the second first
    assign half_d = run ? ~half_q : 1'b0;

    // Control registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_q <= tdiv_pkg::CSR_RST;
            flag_q <= '0;
            prescale_q <= tdiv_pkg::PRESCALE_RST;
            cascade_q <= tdiv_pkg::CASCADE_RST;
            rdata_q <= 8'h00;
        end else begin
            csr_q <= csr_d;
            flag_q <= flag_d;
            rdata_q <= rdata_d;
            prescale_q <= prescale_d;
            cascade_q <= cascade_d;
        end
    end

    // Halving divider flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_d;
        end
    end

    // All ticks in one register, so each is a flop output one cycle wide (held high for reload 0 with an input pulse every clock)
    // and a cascaded consumer steps at the edge that ends it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= '0;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // One channel per iteration; index i is channel i+1
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [7:0] reload_q;
        logic [7:0] reload_d;
        logic [7:0] cnt_q;
        logic [7:0] cnt_d;
        wire logic wr_rel = bus.io_wr && (bus.io_addr == tdiv_pkg::RELOAD_OFF[i]);
        wire logic at_zero = cnt_q == 8'h00;
        wire logic [7:0] cnt_dec = cnt_q - 8'h01;
        wire logic [7:0] cnt_next = at_zero ? reload_q : cnt_dec;

        // Channels 2-7 may take channel 1's pulse; it is consumed at the
        // edge that ends the pulse, i.e. its falling edge.
        // The cascade input is gated by run too, so a stop freezes all;
        // channels 1 and 8-10 always run from the base tick
        if (i >= 1 && i <= 6) begin : g_casc
            wire logic casc = cascade_q[tdiv_pkg::CASC_LSB + i - 1];
            assign in_pulse[i] = casc ? (run && pulse_q[0]) : base_tick;
        end else begin : g_base
            assign in_pulse[i] = base_tick;
        end

        // Reload holds a new value until the counter next wraps, so a
        // write never disturbs the count already under way
        assign reload_d = wr_rel ? bus.io_wdata : reload_q;

        // Next count: load at zero, else one down; frozen between pulses
        assign cnt_d = in_pulse[i] ? cnt_next : cnt_q;
        // Tick follows the input pulse that finds the counter at zero
        assign pulse_d[i] = in_pulse[i] && at_zero;

        // Reload register
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                reload_q <= tdiv_pkg::RELOAD_RST;
            end else begin
                reload_q <= reload_d;
            end
        end

        // Down counter
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_d;
            end
        end
    end
endmodule : tdiv_timers

// ===== hw/tdiv_ctrl.sv
// Controller end: turns software orders into register accesses, watches outputs
module tdiv_ctrl #(
    parameter int NCH = tdiv_pkg::NCH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    tdiv_if.host bus,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    output logic irq_out
);
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic io_wr_q;
    logic io_rd_q;
    logic rd_pend_q;
    logic [7:0] result_q;
    logic [NCH-1:0] seen_q;
    logic [NCH-1:0] seen_d;
    logic [7:0] sw_rdata_q;
    logic [7:0] rmux;

    // Decode of the software port
    wire logic cmd_wr = sw_wr && sw_addr == tdiv_pkg::H_OFF_CMD;
    wire logic clr_lo = sw_rd && sw_addr == tdiv_pkg::H_OFF_SEEN_LO;
    wire logic clr_hi = sw_rd && sw_addr == tdiv_pkg::H_OFF_SEEN_HI;
    wire logic [NCH-1:0] clr_mask = {{(NCH-8){clr_hi}}, {8{clr_lo}}};

    // Pulse seen flags; a pulse in the read cycle survives the clear
    assign seen_d = (seen_q & ~clr_mask) | bus.tick;

    // Read mux for software
    always_comb begin
        unique case (sw_addr)
            tdiv_pkg::H_OFF_ADDR: rmux = addr_q;
            tdiv_pkg::H_OFF_WDATA: rmux = wdata_q;
            tdiv_pkg::H_OFF_RESULT: rmux = result_q;
            tdiv_pkg::H_OFF_STATUS: rmux = {5'h00, bus.irq_prio, bus.irq_req};
            tdiv_pkg::H_OFF_SEEN_LO: rmux = seen_q[7:0];
            tdiv_pkg::H_OFF_SEEN_HI: rmux = {6'h00, seen_q[NCH-1:8]};
            default: rmux = 8'h00;
        endcase
    end

    assign bus.io_addr = addr_q;
    assign bus.io_wdata = wdata_q;
    assign bus.io_wr = io_wr_q;
    assign bus.io_rd = io_rd_q;
    assign sw_rdata = sw_rdata_q;
    assign irq_out = bus.irq_req;

    // Accesses go out in the order software issues them, so setup order
    // and priority-last are kept by the caller
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            io_wr_q <= 1'b0;
            io_rd_q <= 1'b0;
            rd_pend_q <= 1'b0;
            result_q <= 8'h00;
            seen_q <= '0;
            sw_rdata_q <= 8'h00;
        end else begin
            if (sw_wr && sw_addr == tdiv_pkg::H_OFF_ADDR) begin
                addr_q <= sw_wdata;
            end
            if (sw_wr && sw_addr == tdiv_pkg::H_OFF_WDATA) begin
                wdata_q <= sw_wdata;
            end
            io_wr_q <= cmd_wr && sw_wdata[tdiv_pkg::H_CMD_WR_BIT];
            // Write wins if both bits are set; never both strobes at once
            io_rd_q <= cmd_wr && sw_wdata[tdiv_pkg::H_CMD_RD_BIT]
                && !sw_wdata[tdiv_pkg::H_CMD_WR_BIT];
            rd_pend_q <= io_rd_q;
            // Whole status byte kept, so every flag seen can be handled
            if (rd_pend_q) begin
                result_q <= bus.io_rdata;
            end
            seen_q <= seen_d;
            sw_rdata_q <= sw_rd ? rmux : 8'h00;
        end
    end
endmodule : tdiv_ctrl

// ===== verification/tdiv_link_assertions.sv
// Checker on the link between the divider block and its controller
module tdiv_link_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic [tdiv_pkg::NCH-1:0] tick,
    input wire logic irq_req,
    input wire logic [1:0] irq_prio
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic run_q;
    logic half_q;
    logic casc2_q;
    logic [6:0] tick_q;
    wire csr_rd = io_rd && io_addr == tdiv_pkg::OFF_CSR;
    wire csr_wr = io_wr && io_addr == tdiv_pkg::OFF_CSR;
    wire pre_wr = io_wr && io_addr == tdiv_pkg::OFF_PRESCALE;
    wire cas_wr = io_wr && io_addr == tdiv_pkg::OFF_CASCADE;
    // Shadow copies of the written controls, same timing as the block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            half_q <= 1'b1;
            casc2_q <= 1'b0;
            tick_q <= 7'h00;
        end else begin
            run_q <= csr_wr ? io_wdata[0] : run_q;
            half_q <= pre_wr ? io_wdata[0] : half_q;
            casc2_q <= cas_wr ? io_wdata[2] : casc2_q;
            tick_q <= tick[6:0];
        end
    end
    stop_freeze_a: assert property (tick != '0 |-> $past(run_q))
        else $error("tick while stopped");
    half_pulse_a: assert property ((tick != '0 && half_q && $past(half_q))
        |=> (tick & $past(tick)) == '0) else $error("tick longer than a cycle");
    casc_src_a: assert property ((tick[1] && $past(casc2_q)) |-> $past(tick[0]))
        else $error("cascaded tick without source tick");
    prio_gate_a: assert property (irq_req |-> irq_prio != 2'b00)
        else $error("request with priority zero");
    prio_copy_a: assert property ($past(cas_wr) |-> irq_prio == $past(io_wdata[1:0]))
        else $error("priority not as written");
    read_drop_a: assert property ((csr_rd && tick[6:0] == 7'h00) |=> !irq_req)
        else $error("request kept after status read");
    idle_data_a: assert property (!io_rd |=> io_rdata == 8'h00)
        else $error("read data outside answer cycle");
    run_bit_a: assert property (csr_rd |=> io_rdata[0] == 1'b0)
        else $error("status bit 0 not zero");
    flag_seen_a: assert property (csr_rd |=>
        (io_rdata[7:1] & $past(tick_q)) == $past(tick_q)) else $error("flag lost");
    wo_read_a: assert property ((io_rd && io_addr == tdiv_pkg::OFF_CASCADE)
        |=> io_rdata == 8'h00) else $error("write-only register read back");
    // Main scenarios reached
    cover property (tick[0]);
    cover property (csr_rd && irq_req);
    cover property (tick[1] && casc2_q);
endmodule : tdiv_link_assertions

// ===== verification/ten_channel_reload_divider_timers_bench.sv
// Bench: software port of the controller driving the divider block
module ten_channel_reload_divider_timers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [7:0] sw_rdata;
    logic irq_out;
    logic [7:0] vec;
    logic [7:0] rd;
    int n_fail = 0;
    int tests_run = 0;
    int gap;
    tdiv_if link();
    tdiv_timers i_tdiv_timers (.ref_clk(ref_clk), .rst_n(rst_n), .bus(link),
        .irq_vector_offset(vec));
    tdiv_ctrl i_tdiv_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .bus(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .irq_out(irq_out));
    tdiv_link_assertions i_tdiv_link_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
        .io_addr(link.io_addr), .io_wdata(link.io_wdata), .io_wr(link.io_wr),
        .io_rd(link.io_rd), .io_rdata(link.io_rdata), .tick(link.tick),
        .irq_req(link.irq_req), .irq_prio(link.irq_prio));
    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : sw_write

    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : sw_read

    // Device write through the controller; two spare cycles let it land
    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        sw_write(tdiv_pkg::H_OFF_ADDR, a);
        sw_write(tdiv_pkg::H_OFF_WDATA, d);
        sw_write(tdiv_pkg::H_OFF_CMD, 8'h01);
        repeat (2) @(posedge ref_clk);
    endtask : dev_wr

    // Result register is only valid three cycles after the command
    task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
        sw_write(tdiv_pkg::H_OFF_ADDR, a);
        sw_write(tdiv_pkg::H_OFF_CMD, 8'h02);
        repeat (3) @(posedge ref_clk);
        sw_read(tdiv_pkg::H_OFF_RESULT, d);
    endtask : dev_rd

    // Bounded wait for the next tick; returns cycles waited
    task automatic wait_tick(input int ch, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (link.tick[ch] !== 1'b1 && n < 600);
        if (n >= 600) begin
            n_fail++;
            test_done();
        end
    endtask : wait_tick

    task automatic div_case(input int ch, input logic [7:0] rl, input logic [7:0] half,
                            input logic [7:0] casc, input int exp);
        dev_wr(tdiv_pkg::OFF_CSR, 8'h00);
        dev_wr(tdiv_pkg::OFF_PRESCALE, half);
        dev_wr(tdiv_pkg::OFF_CASCADE, casc);
        dev_wr(tdiv_pkg::RELOAD_OFF[ch], rl);
        dev_wr(tdiv_pkg::OFF_CSR, 8'h01);
        wait_tick(ch, gap);
        wait_tick(ch, gap);
        wait_tick(ch, gap);
        chk("tick gap", 16'(exp), 16'(gap));
    endtask : div_case

    task automatic t_reset;
        chk("ticks", 16'h0000, 16'(link.tick));
        chk("irq", 16'h0000, 16'(irq_out));
        dev_rd(tdiv_pkg::OFF_CSR, rd);
        chk("status", 16'h0000, 16'(rd));
    endtask : t_reset

    task automatic t_divide;
        div_case(0, 8'h00, 8'h01, 8'h00, 2);
        div_case(7, 8'hff, 8'h00, 8'h00, 256);
        div_case(9, 8'h05, 8'h01, 8'h00, 12);
        sw_read(tdiv_pkg::H_OFF_SEEN_HI, rd);
        chk("seen ch10", 16'h0002, 16'(rd & 8'h02));
        dev_wr(tdiv_pkg::RELOAD_OFF[0], 8'h01);
        div_case(1, 8'h02, 8'h00, 8'h04, 6);
    endtask : t_divide

    task automatic t_irq;
        dev_wr(tdiv_pkg::OFF_PRESCALE, 8'h00);
        dev_wr(tdiv_pkg::OFF_CASCADE, 8'h00);
        dev_wr(tdiv_pkg::RELOAD_OFF[0], 8'hff);
        dev_wr(tdiv_pkg::OFF_CSR, 8'h03);
        wait_tick(0, gap);
        wait_tick(0, gap);
        dev_wr(tdiv_pkg::OFF_CSR, 8'h02);
        chk("irq masked", 16'h0000, 16'(irq_out));
        dev_wr(tdiv_pkg::OFF_CASCADE, 8'h01);
        chk("irq raised", 16'h0001, 16'(irq_out));
        sw_read(tdiv_pkg::H_OFF_STATUS, rd);
        chk("status port", 16'h0003, 16'(rd));
        dev_rd(tdiv_pkg::OFF_CSR, rd);
        chk("ch1 flag", 16'h0002, 16'(rd & 8'h03));
        chk("irq dropped", 16'h0000, 16'(irq_out));
        dev_rd(tdiv_pkg::OFF_CSR, rd);
        chk("flags cleared", 16'h0000, 16'(rd));
    endtask : t_irq

    task automatic t_map;
        for (int p = 1; p < 4; p++) begin
            dev_wr(tdiv_pkg::OFF_CASCADE, 8'(p));
            chk("priority", 16'(p), 16'(link.irq_prio));
        end
        dev_rd(tdiv_pkg::OFF_CASCADE, rd);
        chk("write-only read", 16'h0000, 16'(rd));
        dev_rd(8'hb2, rd);
        chk("unmapped read", 16'h0000, 16'(rd));
        chk("vector", 16'(tdiv_pkg::IRQ_VEC_OFF), 16'(vec));
    endtask : t_map

    // Reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_divide();
        t_irq();
        t_map();
        test_done();
    end
endmodule : ten_channel_reload_divider_timers_bench
